// ===== rtl/at8t_pkg.sv
`default_nettype none
package at8t_pkg;
    localparam int CNT_W = 8;
    localparam int PRESCALE_W = 10;

    localparam logic [5:0] CTRL_ADDR = 6'h10;
    localparam logic [5:0] COUNTER_ADDR = 6'h11;
    localparam logic [5:0] COMPARE_ADDR = 6'h12;
    localparam logic [5:0] ASYNC_STATUS_ADDR = 6'h13;
    localparam logic [5:0] TIMER_FLAG_ADDR = 6'h14;
    localparam logic [5:0] TIMER_MASK_ADDR = 6'h39;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] TIMER_MASK_RESET = 8'h00;
    localparam logic [7:0] TIMER_FLAG_RESET = 8'h00;

    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hFF;

    localparam int FLAG_COMPARE_BIT = 7;
    localparam int FLAG_OVERFLOW_BIT = 6;
    localparam int ASYNC_SELECT_BIT = 3;
    localparam int ASYNC_COUNTER_BUSY_BIT = 2;
    localparam int ASYNC_COMPARE_BUSY_BIT = 1;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PHASE_PWM = 2'h1;
    localparam logic [1:0] MODE_CLEAR_ON_MATCH = 2'h2;
    localparam logic [1:0] MODE_FAST_PWM = 2'h3;

    localparam logic [1:0] OUT_OFF = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR = 2'h2;
    localparam logic [1:0] OUT_SET = 2'h3;

    localparam logic [2:0] CLK_STOPPED = 3'h0;
    localparam logic [2:0] CLK_DIRECT = 3'h1;

    // Index is the clock select code; divisors 1,8,32,64,128,256,1024
    localparam logic [PRESCALE_W-1:0] PRESCALE_MASK [8] = '{
        10'h000, 10'h000, 10'h007, 10'h01F, 10'h03F, 10'h07F, 10'h0FF, 10'h3FF
    };

    typedef struct packed {
        logic forceCompare;
        logic [1:0] outMode;
        logic [1:0] waveMode;
        logic [2:0] clockSelect;
    } at8t_ctrl_t;
endpackage : at8t_pkg
`default_nettype wire

// ===== rtl/at8t_timer.sv
// What this block does
// - Counter and compare registers are eight bits
// - Requests flagged in flag register, individually masked
// - Clocked via prescaler or from oscillator pins
// - Clock select picks source for up/down counting
// - No clock selected keeps counter holding value
// - Compare buffered value with counter every tick
// - Match drives PWM or frequency output pin
// - Match sets compare flag; masked flag raises request
// - Zero is the bottom of the range
// - All ones is the maximum of range
// - Top is maximum or compare value per mode
// - After reset timer takes io clock but stays stopped (no clock selected)
// - Async select bit takes clock from oscillator
// - Async operation governed by own status register
// - Counter counts both upward and downward
`default_nettype none
module at8t_timer (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [5:0] ioAddr,
    input wire logic [7:0] ioWriteData,
    input wire logic ioWrite,
    input wire logic ioRead,
    output logic [7:0] ioReadData,
    input wire logic oscPinIn,
    output logic oscPinOut,
    output logic compareOutputPin,
    output logic compareOutputDrive,
    output logic irqCompare,
    output logic irqOverflow
);
    import at8t_pkg::*;

    at8t_ctrl_t ctrl;
    logic [CNT_W-1:0] counterValue;
    logic [CNT_W-1:0] compareValue;
    logic [CNT_W-1:0] activeCompare;
    logic [CNT_W-1:0] counterPend;
    logic [CNT_W-1:0] comparePend;
    logic counterBusy;
    logic compareBusy;
    logic asyncClockSelect;
    logic [7:0] timerMaskReg;
    logic [7:0] timerFlagReg;
    logic [PRESCALE_W-1:0] prescale;
    logic oscMeta;
    logic oscSync;
    logic oscPrev;
    logic countDown;

    logic oscEdge;
    logic srcTick;
    logic timerTick;
    logic match;
    logic overflowEvent;
    logic atMax;
    logic pwmMode;
    logic [CNT_W-1:0] next_counter;
    logic next_countDown;
    logic wrCtrl;
    logic wrCounter;
    logic wrCompare;
    logic wrAsync;
    logic wrFlag;
    logic wrMask;
    logic counterLoad;
    logic compareLoad;

    assign wrCtrl = ioWrite && ioAddr == CTRL_ADDR;
    assign wrCounter = ioWrite && ioAddr == COUNTER_ADDR;
    assign wrCompare = ioWrite && ioAddr == COMPARE_ADDR;
    assign wrAsync = ioWrite && ioAddr == ASYNC_STATUS_ADDR;
    assign wrFlag = ioWrite && ioAddr == TIMER_FLAG_ADDR;
    assign wrMask = ioWrite && ioAddr == TIMER_MASK_ADDR;

    // Only oscSync and oscPrev feed the edge detector; oscMeta stays private
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            oscMeta <= 1'b0;
            oscSync <= 1'b0;
            oscPrev <= 1'b0;
            oscPinOut <= 1'b1;
        end
        else
        begin
            oscMeta <= oscPinIn;
            oscSync <= oscMeta;
            oscPrev <= oscSync;
            oscPinOut <= ~oscSync;
        end
    end

    assign oscEdge = oscSync && !oscPrev;
    assign srcTick = asyncClockSelect ? oscEdge : 1'b1;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            prescale <= '0;
        else if (srcTick)
            prescale <= prescale + 1'b1;
    end

    always_comb
    begin
        unique case (ctrl.clockSelect)
            CLK_STOPPED: timerTick = 1'b0;
            CLK_DIRECT: timerTick = srcTick;
            default: timerTick = srcTick && (prescale & PRESCALE_MASK[ctrl.clockSelect])
                == PRESCALE_MASK[ctrl.clockSelect];
        endcase
    end

    assign pwmMode = ctrl.waveMode == MODE_PHASE_PWM || ctrl.waveMode == MODE_FAST_PWM;
    assign atMax = counterValue == MAX;
    assign match = timerTick && counterValue == activeCompare;

    always_comb
    begin
        next_counter = counterValue + 1'b1;
        next_countDown = 1'b0;
        overflowEvent = timerTick && atMax;
        unique case (ctrl.waveMode)
            MODE_CLEAR_ON_MATCH:
            begin
                if (counterValue == activeCompare)
                    next_counter = BOTTOM;
            end
            MODE_PHASE_PWM:
            begin
                overflowEvent = timerTick && counterValue == BOTTOM;
                next_countDown = countDown;
                if (!countDown && atMax)
                begin
                    next_counter = MAX - 1'b1;
                    next_countDown = 1'b1;
                end
                else if (countDown && counterValue == BOTTOM)
                begin
                    next_counter = BOTTOM + 1'b1;
                    next_countDown = 1'b0;
                end
                else if (countDown)
                    next_counter = counterValue - 1'b1;
            end
            default:
            begin
                next_counter = counterValue + 1'b1;
            end
        endcase
    end

    // Async writes wait for an oscillator edge so the counter never sees a torn value
    assign counterLoad = asyncClockSelect ? (counterBusy && oscEdge) : wrCounter;
    assign compareLoad = asyncClockSelect ? (compareBusy && oscEdge) : wrCompare;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            counterPend <= COUNTER_RESET;
            comparePend <= COMPARE_RESET;
            counterBusy <= 1'b0;
            compareBusy <= 1'b0;
        end
        else
        begin
            if (wrCounter)
                counterPend <= ioWriteData;
            if (wrCompare)
                comparePend <= ioWriteData;
            if (wrCounter && asyncClockSelect)
                counterBusy <= 1'b1;
            else if (counterLoad || !asyncClockSelect)
                counterBusy <= 1'b0;
            if (wrCompare && asyncClockSelect)
                compareBusy <= 1'b1;
            else if (compareLoad || !asyncClockSelect)
                compareBusy <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            counterValue <= COUNTER_RESET;
            countDown <= 1'b0;
        end
        else if (counterLoad)
            counterValue <= asyncClockSelect ? counterPend : ioWriteData;
        else if (timerTick)
        begin
            counterValue <= next_counter;
            countDown <= next_countDown;
        end
        else if (!pwmMode)
            countDown <= 1'b0;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            compareValue <= COMPARE_RESET;
        else if (compareLoad)
            compareValue <= asyncClockSelect ? comparePend : ioWriteData;
    end

    // PWM modes defer the load to top so one period never sees two thresholds
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            activeCompare <= COMPARE_RESET;
        else if (!pwmMode || (timerTick && atMax))
            activeCompare <= compareValue;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl <= CTRL_RESET;
            asyncClockSelect <= 1'b0;
            timerMaskReg <= TIMER_MASK_RESET;
        end
        else
        begin
            if (wrCtrl)
                ctrl <= ioWriteData;
            else
                ctrl.forceCompare <= 1'b0;
            if (wrAsync)
                asyncClockSelect <= ioWriteData[ASYNC_SELECT_BIT];
            if (wrMask)
                timerMaskReg <= ioWriteData;
        end
    end

    // Setting beats a write-one clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            timerFlagReg <= TIMER_FLAG_RESET;
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (wrFlag && ioWriteData[i])
                    timerFlagReg[i] <= 1'b0;
            end
            if (match)
                timerFlagReg[FLAG_COMPARE_BIT] <= 1'b1;
            if (overflowEvent)
                timerFlagReg[FLAG_OVERFLOW_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqCompare <= 1'b0;
            irqOverflow <= 1'b0;
        end
        else
        begin
            irqCompare <= timerFlagReg[FLAG_COMPARE_BIT]
                && timerMaskReg[FLAG_COMPARE_BIT];
            irqOverflow <= timerFlagReg[FLAG_OVERFLOW_BIT]
                && timerMaskReg[FLAG_OVERFLOW_BIT];
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            compareOutputPin <= 1'b0;
            compareOutputDrive <= 1'b0;
        end
        else
        begin
            compareOutputDrive <= ctrl.outMode != OUT_OFF;
            if (!pwmMode && (match || ctrl.forceCompare))
            begin
                unique case (ctrl.outMode)
                    OUT_TOGGLE: compareOutputPin <= ~compareOutputPin;
                    OUT_CLEAR: compareOutputPin <= 1'b0;
                    OUT_SET: compareOutputPin <= 1'b1;
                    OUT_OFF: compareOutputPin <= compareOutputPin;
                endcase
            end
            else if (ctrl.waveMode == MODE_FAST_PWM && ctrl.outMode[1])
            begin
                if (match)
                    compareOutputPin <= ctrl.outMode == OUT_SET;
                else if (timerTick && atMax)
                    compareOutputPin <= ctrl.outMode == OUT_CLEAR;
            end
            else if (ctrl.waveMode == MODE_PHASE_PWM && ctrl.outMode[1] && match)
                compareOutputPin <= (ctrl.outMode == OUT_SET) ^ countDown;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            ioReadData <= 8'h00;
        else if (ioRead)
        begin
            unique case (ioAddr)
                CTRL_ADDR: ioReadData <= {1'b0, ctrl[6:0]};
                COUNTER_ADDR: ioReadData <= counterValue;
                COMPARE_ADDR: ioReadData <= compareValue;
                ASYNC_STATUS_ADDR: ioReadData <= {4'h0, asyncClockSelect, counterBusy,
                    compareBusy, 1'b0};
                TIMER_FLAG_ADDR: ioReadData <= timerFlagReg;
                TIMER_MASK_ADDR: ioReadData <= timerMaskReg;
                default: ioReadData <= 8'h00;
            endcase
        end
    end
endmodule : at8t_timer
`default_nettype wire

// ===== verif/at8t_timer_props.sv
`default_nettype none
module at8t_timer_props
    import at8t_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [5:0] ioAddr,
    input wire logic [7:0] ioWriteData,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioReadData,
    input wire logic oscPinIn,
    input wire logic oscPinOut,
    input wire logic compareOutputDrive,
    input wire logic irqCompare,
    input wire logic irqOverflow
);
    logic [7:0] maskCopy;
    logic [1:0] outCopy;
    logic asyncCopy;
    logic [2:0] upCnt;
    logic ctrlWr;
    logic mapped;
    assign ctrlWr = ioWrite && ioAddr == CTRL_ADDR;
    assign mapped = ioAddr inside {[CTRL_ADDR:TIMER_FLAG_ADDR], TIMER_MASK_ADDR};
    // Shadows of the mask, output-mode and async-select fields, mirrored from the bus
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            maskCopy <= 8'h00;
            outCopy <= 2'h0;
            asyncCopy <= 1'b0;
            upCnt <= 3'h0;
        end
        else
        begin
            if (ioWrite && ioAddr == TIMER_MASK_ADDR)
                maskCopy <= ioWriteData;
            if (ctrlWr)
                outCopy <= ioWriteData[6:5];
            if (ioWrite && ioAddr == ASYNC_STATUS_ADDR)
                asyncCopy <= ioWriteData[ASYNC_SELECT_BIT];
            if (upCnt != 3'h4)
                upCnt <= upCnt + 3'h1;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    unmapped_reads_zero_a: assert property (ioRead && !mapped |=> ioReadData == 8'h00)
        else $error("unmapped read not zero");
    mask_readback_a: assert property (
        ioRead && !ioWrite && ioAddr == TIMER_MASK_ADDR |=> ioReadData == $past(maskCopy))
        else $error("mask readback wrong");
    force_reads_zero_a: assert property (ioRead && ioAddr == CTRL_ADDR |=> !ioReadData[7])
        else $error("force bit read as one");
    read_data_stands_a: assert property (!ioRead |=> $stable(ioReadData))
        else $error("read data changed without read");
    async_readback_a: assert property (
        ioRead && !ioWrite && ioAddr == ASYNC_STATUS_ADDR
        |=> ioReadData[ASYNC_SELECT_BIT] == $past(asyncCopy))
        else $error("async select readback wrong");
    pin_drive_follows_a: assert property (
        ctrlWr ##1 !ctrlWr [*2] |-> compareOutputDrive == (outCopy != OUT_OFF))
        else $error("pin drive does not follow output mode");
    osc_inverse_a: assert property (
        $stable(oscPinIn) [*4] ##0 upCnt == 3'h4 |-> oscPinOut == !oscPinIn)
        else $error("oscillator output not inverse of input");
    compare_irq_gated_a: assert property (irqCompare |-> $past(maskCopy[7]))
        else $error("compare request without mask bit");
    overflow_irq_gated_a: assert property (irqOverflow |-> $past(maskCopy[6]))
        else $error("overflow request without mask bit");
endmodule : at8t_timer_props
`default_nettype wire

// ===== verif/at8t_timer_bench.sv
`default_nettype none
module at8t_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import at8t_pkg::*;
    logic mclk, reset_n, ioWrite, ioRead, oscPinIn, oscPinOut;
    logic [5:0] ioAddr;
    logic [7:0] ioWriteData, ioReadData, a, b;
    logic compareOutputPin, compareOutputDrive, irqCompare, irqOverflow;
    int nErrors = 0;
    int checkCount = 0;
    int cycles = 0;
    at8t_timer i_dut (.mclk(mclk), .reset_n(reset_n), .ioAddr(ioAddr),
        .ioWriteData(ioWriteData), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioReadData(ioReadData), .oscPinIn(oscPinIn), .oscPinOut(oscPinOut),
        .compareOutputPin(compareOutputPin), .compareOutputDrive(compareOutputDrive),
        .irqCompare(irqCompare), .irqOverflow(irqOverflow));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finishTest;
        $display("checks %0d errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finishTest
    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        @(negedge mclk);
        ioAddr = ad;
        ioWriteData = d;
        ioWrite = 1'b1;
        @(negedge mclk);
        ioWrite = 1'b0;
    endtask : wr
    // Two back-to-back reads sample two clock edges apart
    task automatic rd(input logic [5:0] ad, output logic [7:0] d);
        @(negedge mclk);
        ioAddr = ad;
        ioRead = 1'b1;
        @(negedge mclk);
        ioRead = 1'b0;
        d = ioReadData;
    endtask : rd
    task automatic testReset;
        logic [5:0] adr [6] = '{CTRL_ADDR, COUNTER_ADDR, COMPARE_ADDR,
            ASYNC_STATUS_ADDR, TIMER_FLAG_ADDR, TIMER_MASK_ADDR};
        foreach (adr[i])
        begin
            rd(adr[i], a);
            check("reset value", a, 8'h00);
        end
        wr(6'h20, 8'hFF);
        rd(6'h20, a);
        check("unmapped", a, 8'h00);
    endtask : testReset
    task automatic testStop;
        wr(COUNTER_ADDR, 8'hA5);
        repeat (5) @(negedge mclk);
        rd(COUNTER_ADDR, a);
        check("stopped counter", a, 8'hA5);
        wr(COMPARE_ADDR, 8'hFF);
        rd(COMPARE_ADDR, a);
        check("compare width", a, 8'hFF);
    endtask : testStop
    task automatic testCount;
        wr(COMPARE_ADDR, 8'h40);
        wr(TIMER_MASK_ADDR, 8'hC0);
        wr(COUNTER_ADDR, BOTTOM);
        wr(CTRL_ADDR, {1'b0, OUT_TOGGLE, MODE_NORMAL, CLK_DIRECT});
        rd(COUNTER_ADDR, a);
        rd(COUNTER_ADDR, b);
        check("count step", b - a, 8'h02);
        repeat (70) @(negedge mclk);
        rd(TIMER_FLAG_ADDR, a);
        check("compare flag", a, 8'h80);
        check("compare irq", {7'h0, irqCompare}, 8'h01);
        check("toggled pin", {6'h0, compareOutputDrive, compareOutputPin}, 8'h03);
        repeat (200) @(negedge mclk);
        rd(TIMER_FLAG_ADDR, a);
        check("overflow flag", a, 8'hC0);
        check("overflow irq", {7'h0, irqOverflow}, 8'h01);
        wr(CTRL_ADDR, 8'h00);
        wr(TIMER_MASK_ADDR, 8'h00);
        @(negedge mclk);
        check("masked irqs", {6'h0, irqCompare, irqOverflow}, 8'h00);
        wr(TIMER_FLAG_ADDR, 8'hC0);
        rd(TIMER_FLAG_ADDR, a);
        check("flags cleared", a, 8'h00);
    endtask : testCount
    task automatic testCtc;
        wr(COUNTER_ADDR, BOTTOM);
        wr(COMPARE_ADDR, 8'h05);
        wr(CTRL_ADDR, {1'b0, OUT_OFF, MODE_CLEAR_ON_MATCH, CLK_DIRECT});
        repeat (8)
        begin
            rd(COUNTER_ADDR, a);
            check("top bound", {7'h0, a > 8'h05}, 8'h00);
        end
        check("pin released", {7'h0, compareOutputDrive}, 8'h00);
        wr(CTRL_ADDR, 8'h00);
    endtask : testCtc
    task automatic testAsync;
        wr(ASYNC_STATUS_ADDR, 8'h08);
        wr(COUNTER_ADDR, BOTTOM);
        wr(CTRL_ADDR, {1'b0, OUT_OFF, MODE_NORMAL, CLK_DIRECT});
        rd(ASYNC_STATUS_ADDR, a);
        check("async status", a, 8'h0C);
        repeat (6)
        begin
            @(negedge mclk);
            oscPinIn = 1'b1;
            repeat (4) @(negedge mclk);
            oscPinIn = 1'b0;
            repeat (4) @(negedge mclk);
        end
        rd(COUNTER_ADDR, a);
        repeat (20) @(negedge mclk);
        rd(COUNTER_ADDR, b);
        // Write lands on the first edge and wins over its tick
        check("osc ticks", a, 8'h05);
        check("osc idle hold", b, 8'h05);
        check("osc out", {7'h0, oscPinOut}, 8'h01);
        wr(CTRL_ADDR, 8'h00);
        wr(ASYNC_STATUS_ADDR, 8'h00);
    endtask : testAsync
    task automatic testPrescale;
        wr(COUNTER_ADDR, BOTTOM);
        wr(CTRL_ADDR, {1'b0, OUT_OFF, MODE_NORMAL, 3'h2});
        rd(COUNTER_ADDR, a);
        repeat (38) @(negedge mclk);
        rd(COUNTER_ADDR, b);
        // Forty edges apart always hold exactly five divide-by-eight ticks
        check("prescaled step", b - a, 8'h05);
        wr(CTRL_ADDR, 8'h00);
    endtask : testPrescale
    task automatic testFastPwm;
        wr(COUNTER_ADDR, BOTTOM);
        wr(COMPARE_ADDR, 8'h80);
        wr(CTRL_ADDR, {1'b0, OUT_CLEAR, MODE_FAST_PWM, CLK_DIRECT});
        repeat (140) @(negedge mclk);
        check("fast pwm low", {7'h0, compareOutputPin}, 8'h00);
        wr(TIMER_FLAG_ADDR, 8'hC0);
        // New threshold lies ahead of the counter but must wait for top
        wr(COMPARE_ADDR, 8'hC0);
        repeat (60) @(negedge mclk);
        rd(TIMER_FLAG_ADDR, a);
        check("buffered compare", a, 8'h00);
        repeat (80) @(negedge mclk);
        check("fast pwm high", {7'h0, compareOutputPin}, 8'h01);
        wr(CTRL_ADDR, 8'h00);
    endtask : testFastPwm
    task automatic testPhasePwm;
        wr(COUNTER_ADDR, BOTTOM);
        wr(COMPARE_ADDR, 8'h40);
        wr(CTRL_ADDR, {1'b0, OUT_CLEAR, MODE_PHASE_PWM, CLK_DIRECT});
        repeat (298) @(negedge mclk);
        rd(COUNTER_ADDR, a);
        rd(COUNTER_ADDR, b);
        check("down count", a - b, 8'h02);
        check("phase pin low", {7'h0, compareOutputPin}, 8'h00);
        repeat (160) @(negedge mclk);
        check("phase pin high", {7'h0, compareOutputPin}, 8'h01);
        wr(CTRL_ADDR, 8'h00);
    endtask : testPhasePwm
    task automatic testForce;
        wr(CTRL_ADDR, {1'b1, OUT_CLEAR, MODE_NORMAL, CLK_STOPPED});
        @(negedge mclk);
        check("forced clear", {7'h0, compareOutputPin}, 8'h00);
        wr(CTRL_ADDR, {1'b1, OUT_SET, MODE_NORMAL, CLK_STOPPED});
        @(negedge mclk);
        check("forced set", {7'h0, compareOutputPin}, 8'h01);
        wr(CTRL_ADDR, 8'h00);
    endtask : testForce
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Tests need about 1300 cycles; the ceiling leaves ample margin
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nErrors++;
            finishTest();
        end
    end
    initial
    begin
        reset_n = 1'b0;
        ioAddr = 6'h00;
        ioWriteData = 8'h00;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        oscPinIn = 1'b0;
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        testReset();
        testStop();
        testCount();
        testCtc();
        testAsync();
        testPrescale();
        testFastPwm();
        testPhasePwm();
        testForce();
        finishTest();
    end
endmodule : at8t_timer_bench
bind at8t_timer at8t_timer_props i_props (.mclk(mclk), .reset_n(reset_n), .ioAddr(ioAddr),
    .ioWriteData(ioWriteData), .ioWrite(ioWrite), .ioRead(ioRead), .ioReadData(ioReadData),
    .oscPinIn(oscPinIn), .oscPinOut(oscPinOut), .compareOutputDrive(compareOutputDrive),
    .irqCompare(irqCompare), .irqOverflow(irqOverflow));
`default_nettype wire
